/* umm_pkg.sv */
// Constants, types and behaviour notes for the unified memory mapper
// Notes on behaviour
// RQ1: Byte mode: code page select 00..11 maps exactly one program page into data space.
// RQ2: Word mode: select 00/01 maps pages zero and one, 10/11 pages two and three.
// RQ3: Byte mode: the selected page may sit in the lower or upper data half.
// RQ4: Pointer width select resets to byte mode on 8-bit cores, word mode on 16-bit.
// RQ5: Fetch from data memory is possible only while upper program enable is 0.
// RQ6: Executing from data memory, flow passes freely between pages zero/one and ROM.
// RQ7: Executing from data memory, pages two and three cannot be fetched.
// RQ8: Utility ROM appears in data space from offset 8000h.
// RQ9: Selected program page or pages appear in data space from offset 0000h.
// RQ10: Data memory is two byte banks sharing a word address; both always read.
// RQ11: Fetch takes the full 16-bit word; data takes the word or one byte.
// RQ12: Byte read: word address drops pointer LSB; LSB then steers the byte.
// RQ13: Byte write: pointer upper bits address word; LSB enables one bank only.
// RQ14: Software must place executable words at even byte addresses.
// RQ15: No segment is ever accessed as program and data at once.
// RQ16: Data memory appears in program space from address A000h.
// RQ17: Program pages zero and one are always fetchable from address 0000h.
// RQ18: Pages two and three are fetchable from 8000h only while upper enable is 1.
// RQ19: Upper enable at 1 blocks fetch from utility ROM and data memory.
// RQ20: Supports 32k (64k) x16 program, 8k x16 utility ROM, 16k x16 SRAM.
// RQ21: Data pointers reach all three areas; execution possible from each.
// RQ22: Physical data memory should stay within word addresses 0000h..3FFFh.
`default_nettype none
package umm_pkg;
    localparam int ADDR_W    = 16;
    localparam int WORD_W    = 16;
    localparam int BYTE_W    = 8;
    localparam int ROM_AW    = 13;
    localparam int SRAM_AW   = 14;
    localparam int ROM_WORDS  = 8192;
    localparam int SRAM_WORDS = 16384;

    localparam logic [ADDR_W-1:0] PROG_ROM_BASE  = 16'h8000;
    localparam logic [ADDR_W-1:0] PROG_SRAM_BASE = 16'ha000;

    // Register file
    localparam int REG_AW = 4;
    localparam logic [REG_AW-1:0] REG_CTRL   = 4'h0;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h1;
    localparam int CTRL_CPS_LO  = 0;
    localparam int CTRL_PWS     = 2;
    localparam int CTRL_UPE     = 3;
    localparam int CTRL_HALF    = 4;
    localparam int STAT_EXEC_LO = 0;
    localparam int STAT_FFAULT  = 2;
    localparam int STAT_DFAULT  = 3;
    localparam int STAT_CONFL   = 4;
    localparam logic [1:0] CPS_RESET  = 2'h0;
    localparam logic       UPE_RESET  = 1'h0;
    localparam logic       HALF_RESET = 1'h0;

    typedef enum logic [1:0] {
        UMM_SEG_CODE,
        UMM_SEG_ROM,
        UMM_SEG_SRAM,
        UMM_SEG_NONE
    } umm_seg_type;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] ptr;
        logic [WORD_W-1:0] wdata;
    } umm_dreq_type;

    typedef struct packed {
        umm_seg_type       seg;
        logic [ADDR_W-1:0] waddr;
        logic              lane;
    } umm_map_type;
endpackage : umm_pkg
`default_nettype wire

/* umm_mapper.sv */
// Unified program/data memory mapper with control and status registers
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`default_nettype none
module umm_mapper
    import umm_pkg::*;
#(
    parameter logic WIDE_CORE = 1'b1
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // Register port
    input  wire logic [REG_AW-1:0]    reg_addr,
    input  wire logic [WORD_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [WORD_W-1:0]    reg_rdata,
    // Instruction fetch side
    input  wire logic                 fetch_req,
    input  wire logic [ADDR_W-1:0]    fetch_addr,
    output logic                      fetch_valid,
    output logic      [WORD_W-1:0]    fetch_word,
    output logic                      fetch_fault,
    // Data pointer side
    input  wire umm_dreq_type         data_req,
    output logic                      data_ack,
    output logic      [WORD_W-1:0]    data_rdata,
    output logic                      data_fault,
    // Program memory port
    output logic      [ADDR_W-1:0]    code_addr,
    output logic                      code_rd,
    input  wire logic [WORD_W-1:0]    code_rdata,
    // Utility ROM port
    output logic      [ROM_AW-1:0]    rom_addr,
    output logic                      rom_rd,
    input  wire logic [WORD_W-1:0]    rom_rdata,
    // Data SRAM port
    output logic      [SRAM_AW-1:0]   sram_addr,
    output logic                      sram_rd,
    output logic      [1:0]           sram_wen,
    output logic      [WORD_W-1:0]    sram_wdata,
    input  wire logic [WORD_W-1:0]    sram_rdata
);

    function automatic umm_map_type map_fetch(input logic [ADDR_W-1:0] addr,
                                              input logic upe);
        umm_map_type       m;
        logic [ADDR_W-1:0] rel_rom;
        logic [ADDR_W-1:0] rel_sram;
        rel_rom  = addr - PROG_ROM_BASE;
        rel_sram = addr - PROG_SRAM_BASE;
        m.lane   = 1'b0;
        m.waddr  = addr;
        if (!addr[ADDR_W-1] || upe) begin
            m.seg = UMM_SEG_CODE;                               // RQ17 RQ18
        end else if (addr < PROG_SRAM_BASE) begin
            m.seg   = UMM_SEG_ROM;                              // RQ6
            m.waddr = rel_rom;
        end else if (rel_sram < SRAM_WORDS) begin
            m.seg   = UMM_SEG_SRAM;                             // RQ16 RQ5
            m.waddr = rel_sram;
        end else begin
            m.seg = UMM_SEG_NONE;
        end
        return m;
    endfunction : map_fetch

    // Data space halves depend on where code currently runs
    function automatic umm_map_type map_data(input logic [ADDR_W-1:0] ptr,
                                             input logic word_mode,
                                             input umm_seg_type exec,
                                             input logic [1:0] cps,
                                             input logic half_up);
        umm_map_type m;
        umm_seg_type low_seg;
        umm_seg_type high_seg;
        umm_seg_type other;
        logic        code_in;
        logic        code_upper;
        logic [14:0] off;
        off     = word_mode ? ptr[14:0] : {1'b0, ptr[14:1]};    // RQ12 RQ13
        m.lane  = word_mode ? 1'b0 : ptr[0];
        m.waddr = '0;
        unique case (exec)
            UMM_SEG_SRAM: begin
                low_seg  = UMM_SEG_CODE;                        // RQ9 RQ15
                high_seg = UMM_SEG_ROM;                         // RQ8
            end
            UMM_SEG_ROM: begin
                low_seg  = UMM_SEG_SRAM;
                high_seg = UMM_SEG_CODE;
            end
            UMM_SEG_CODE, UMM_SEG_NONE: begin
                low_seg  = UMM_SEG_SRAM;
                high_seg = UMM_SEG_ROM;
            end
        endcase
        code_in    = (low_seg == UMM_SEG_CODE) || (high_seg == UMM_SEG_CODE);
        other      = (low_seg == UMM_SEG_CODE) ? high_seg : low_seg;
        code_upper = word_mode ? (high_seg == UMM_SEG_CODE) : half_up;   // RQ3
        if (code_in) begin
            m.seg = (ptr[ADDR_W-1] == code_upper) ? UMM_SEG_CODE : other;
        end else begin
            m.seg = ptr[ADDR_W-1] ? high_seg : low_seg;
        end
        unique case (m.seg)
            UMM_SEG_CODE: begin
                if (word_mode) begin
                    m.waddr = {cps[1], off};                    // RQ2
                end else begin
                    m.waddr = {cps, off[13:0]};                 // RQ1
                end
            end
            UMM_SEG_ROM: begin
                m.waddr = {1'b0, off};
                if (off >= ROM_WORDS) begin
                    m.seg = UMM_SEG_NONE;                       // RQ20
                end
            end
            UMM_SEG_SRAM: begin
                m.waddr = {1'b0, off};
                if (off >= SRAM_WORDS) begin
                    m.seg = UMM_SEG_NONE;                       // RQ22
                end
            end
            UMM_SEG_NONE: begin
                m.waddr = '0;
            end
        endcase
        return m;
    endfunction : map_data

    // Control state
    logic [1:0]  code_page_select;
    logic        pointer_width_select;
    logic        upper_program_enable;
    logic        byte_half_upper;
    umm_seg_type exec_seg;
    logic        stat_ffault;
    logic        stat_dfault;
    logic        stat_confl;

    // Request decode
    umm_map_type fmap;
    umm_map_type dmap;
    logic        dreq_any;
    logic        conflict;
    logic        f_code;
    logic        f_rom;
    logic        f_sram;
    logic        d_ok;
    logic        d_code;
    logic        d_rom;
    logic        d_sram;
    logic        d_bad;

    assign fmap     = map_fetch(fetch_addr, upper_program_enable);
    assign dmap     = map_data(data_req.ptr, pointer_width_select, exec_seg,
                               code_page_select, byte_half_upper);
    assign dreq_any = data_req.rd || data_req.wr;
    // Fetch wins; the data access is refused rather than stalled
    assign conflict = fetch_req && dreq_any && (fmap.seg == dmap.seg)
                      && (fmap.seg != UMM_SEG_NONE);            // RQ15
    assign f_code   = fetch_req && (fmap.seg == UMM_SEG_CODE);
    assign f_rom    = fetch_req && (fmap.seg == UMM_SEG_ROM);
    assign f_sram   = fetch_req && (fmap.seg == UMM_SEG_SRAM);
    // Code and ROM are read-only through the mapper
    assign d_bad    = (dmap.seg == UMM_SEG_NONE) || conflict
                      || (data_req.wr && (dmap.seg != UMM_SEG_SRAM));
    assign d_ok     = dreq_any && !d_bad;
    assign d_code   = d_ok && (dmap.seg == UMM_SEG_CODE);
    assign d_rom    = d_ok && (dmap.seg == UMM_SEG_ROM);
    assign d_sram   = d_ok && (dmap.seg == UMM_SEG_SRAM);

    // Memory ports
    assign code_addr  = f_code ? fmap.waddr : dmap.waddr;
    assign code_rd    = f_code || d_code;
    assign rom_addr   = f_rom ? fmap.waddr[ROM_AW-1:0] : dmap.waddr[ROM_AW-1:0];
    assign rom_rd     = f_rom || d_rom;
    assign sram_addr  = f_sram ? fmap.waddr[SRAM_AW-1:0] : dmap.waddr[SRAM_AW-1:0];
    assign sram_rd    = f_sram || (d_sram && data_req.rd);     // RQ10
    assign sram_wdata = pointer_width_select ? data_req.wdata
                        : {2{data_req.wdata[BYTE_W-1:0]}};
    always_comb begin
        sram_wen = 2'b00;
        if (d_sram && data_req.wr) begin
            if (pointer_width_select) begin
                sram_wen = 2'b11;
            end else begin
                sram_wen = dmap.lane ? 2'b10 : 2'b01;           // RQ13
            end
        end
    end

    // Control register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            code_page_select     <= CPS_RESET;
            pointer_width_select <= WIDE_CORE;                  // RQ4
            upper_program_enable <= UPE_RESET;
            byte_half_upper      <= HALF_RESET;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            code_page_select     <= reg_wdata[CTRL_CPS_LO +: 2];
            pointer_width_select <= reg_wdata[CTRL_PWS];
            upper_program_enable <= reg_wdata[CTRL_UPE];
            byte_half_upper      <= reg_wdata[CTRL_HALF];
        end
    end

    // Segment code runs from steers the data map
    always_ff @(posedge core_clk) begin
        if (reset) begin
            exec_seg <= UMM_SEG_CODE;
        end else if (fetch_req && fmap.seg != UMM_SEG_NONE) begin
            exec_seg <= fmap.seg;
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    logic clr_hit;
    assign clr_hit = reg_wr && (reg_addr == REG_STATUS);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stat_ffault <= 1'b0;
            stat_dfault <= 1'b0;
            stat_confl  <= 1'b0;
        end else begin
            stat_ffault <= (fetch_req && fmap.seg == UMM_SEG_NONE)
                           || (stat_ffault && !(clr_hit && reg_wdata[STAT_FFAULT]));
            stat_dfault <= (dreq_any && d_bad)
                           || (stat_dfault && !(clr_hit && reg_wdata[STAT_DFAULT]));
            stat_confl  <= conflict
                           || (stat_confl && !(clr_hit && reg_wdata[STAT_CONFL]));
        end
    end

    // Register read data, valid the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd && reg_addr == REG_CTRL) begin
            reg_rdata <= WORD_W'({byte_half_upper, upper_program_enable,
                                  pointer_width_select, code_page_select});
        end else if (reg_rd && reg_addr == REG_STATUS) begin
            reg_rdata <= WORD_W'({stat_confl, stat_dfault, stat_ffault, exec_seg});
        end else begin
            reg_rdata <= '0;
        end
    end

    // Fetch answer: always the whole word
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fetch_valid <= 1'b0;
            fetch_fault <= 1'b0;
            fetch_word  <= '0;
        end else begin
            fetch_valid <= fetch_req;
            fetch_fault <= fetch_req && (fmap.seg == UMM_SEG_NONE);   // RQ7 RQ19
            if (f_code) begin
                fetch_word <= code_rdata;                       // RQ11
            end else if (f_rom) begin
                fetch_word <= rom_rdata;
            end else if (f_sram) begin
                fetch_word <= sram_rdata;                       // RQ21
            end else begin
                fetch_word <= '0;
            end
        end
    end

    // Data answer: whole word or one steered byte
    logic [WORD_W-1:0] d_word;
    always_comb begin
        d_word = '0;
        if (d_code) begin
            d_word = code_rdata;
        end else if (d_rom) begin
            d_word = rom_rdata;
        end else if (d_sram) begin
            d_word = sram_rdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            data_ack   <= 1'b0;
            data_fault <= 1'b0;
            data_rdata <= '0;
        end else begin
            data_ack   <= dreq_any;
            data_fault <= dreq_any && d_bad;
            if (!(data_req.rd && d_ok)) begin
                data_rdata <= '0;
            end else if (pointer_width_select) begin
                data_rdata <= d_word;
            end else if (dmap.lane) begin
                data_rdata <= {{BYTE_W{1'b0}}, d_word[WORD_W-1:BYTE_W]};   // RQ12
            end else begin
                data_rdata <= {{BYTE_W{1'b0}}, d_word[BYTE_W-1:0]};
            end
        end
    end

    // Checks
    a_reset_width_mode: assert property (        // RQ4
        @(posedge core_clk) disable iff (reset)
        $past(reset) |-> pointer_width_select == WIDE_CORE)
        else $error("pointer width select has wrong reset value");

    a_low_pages_fetch: assert property (         // RQ17
        @(posedge core_clk) disable iff (reset)
        (fetch_req && !fetch_addr[ADDR_W-1]) |-> (code_rd && code_addr == fetch_addr))
        else $error("low program pages not fetched at their address");

    a_upper_fetch_block: assert property (       // RQ19
        @(posedge core_clk) disable iff (reset)
        (fetch_req && upper_program_enable && fetch_addr[ADDR_W-1])
        |-> (code_rd && code_addr == fetch_addr && !f_rom && !f_sram))
        else $error("upper enable did not route fetch to upper pages");

    a_no_upper_pages: assert property (          // RQ7
        @(posedge core_clk) disable iff (reset)
        (fetch_req && !upper_program_enable && fetch_addr[ADDR_W-1]) |-> !f_code)
        else $error("upper program pages fetched while disabled");

    a_sram_prog_base: assert property (          // RQ16
        @(posedge core_clk) disable iff (reset)
        (fetch_req && !upper_program_enable && fetch_addr >= PROG_SRAM_BASE
         && fetch_addr < PROG_SRAM_BASE + 16'(SRAM_WORDS))
        |-> (sram_rd && sram_addr == 14'(fetch_addr - PROG_SRAM_BASE)))
        else $error("data memory not seen at its program base");

    a_same_seg_block: assert property (          // RQ15
        @(posedge core_clk) disable iff (reset)
        conflict |=> (data_fault && data_ack && stat_confl && data_rdata == '0))
        else $error("segment used as program and data together");

    a_byte_bank_write: assert property (         // RQ13
        @(posedge core_clk) disable iff (reset)
        (sram_wen != 2'b00 && !pointer_width_select)
        |-> ($onehot(sram_wen) && sram_wen[1] == data_req.ptr[0]
             && sram_addr == data_req.ptr[14:1]))
        else $error("byte write touched the wrong bank");

    a_byte_lane_read: assert property (          // RQ12
        @(posedge core_clk) disable iff (reset)
        (d_sram && data_req.rd && !pointer_width_select && data_req.ptr[0])
        |=> data_rdata == {8'h00, $past(sram_rdata[WORD_W-1:BYTE_W])})
        else $error("high byte not steered onto the data path");

    a_code_page_byte: assert property (          // RQ1
        @(posedge core_clk) disable iff (reset)
        (d_code && !pointer_width_select) |-> code_addr[15:14] == code_page_select)
        else $error("byte mode mapped the wrong program page");

    a_code_page_word: assert property (          // RQ2
        @(posedge core_clk) disable iff (reset)
        (d_code && pointer_width_select)
        |-> (code_addr[15] == code_page_select[1] && code_addr[14:0] == data_req.ptr[14:0]))
        else $error("word mode mapped the wrong page pair");

    a_rom_data_base: assert property (           // RQ8
        @(posedge core_clk) disable iff (reset)
        (data_req.rd && !fetch_req && pointer_width_select && exec_seg == UMM_SEG_SRAM
         && data_req.ptr >= PROG_ROM_BASE && data_req.ptr < PROG_SRAM_BASE)
        |-> (rom_rd && rom_addr == data_req.ptr[ROM_AW-1:0]) ##1 (data_ack && !data_fault))
        else $error("utility ROM not seen at data offset 8000h");

    a_full_fetch_word: assert property (         // RQ11
        @(posedge core_clk) disable iff (reset)
        f_code |=> (fetch_valid && fetch_word == $past(code_rdata)))
        else $error("fetch did not return the whole word");

endmodule : umm_mapper
`default_nettype wire

/* umm_mem_model.sv */
// Memory model for the program, utility ROM and data SRAM ports of the mapper
`default_nettype none
package umm_model_pkg;
    timeunit 1ns;
    timeprecision 1ns;
    function automatic logic [15:0] code_val(input logic [15:0] a);
        return a ^ 16'h5a5a;
    endfunction : code_val
    function automatic logic [15:0] rom_val(input logic [15:0] a);
        return {3'h5, a[12:0]};
    endfunction : rom_val
    function automatic logic [15:0] sram_init(input logic [15:0] a);
        return a ^ 16'hc3c3;
    endfunction : sram_init
endpackage : umm_model_pkg

module umm_mem_model
    import umm_pkg::*, umm_model_pkg::*;
(
    // Clock
    input  wire logic                 core_clk,
    // Program memory
    input  wire logic [ADDR_W-1:0]    code_addr,
    input  wire logic                 code_rd,
    output logic      [WORD_W-1:0]    code_rdata,
    // Utility ROM
    input  wire logic [ROM_AW-1:0]    rom_addr,
    input  wire logic                 rom_rd,
    output logic      [WORD_W-1:0]    rom_rdata,
    // Data SRAM
    input  wire logic [SRAM_AW-1:0]   sram_addr,
    input  wire logic                 sram_rd,
    input  wire logic [1:0]           sram_wen,
    input  wire logic [WORD_W-1:0]    sram_wdata,
    output logic      [WORD_W-1:0]    sram_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [WORD_W-1:0] sram [SRAM_WORDS];

    initial begin
        for (int i = 0; i < SRAM_WORDS; i++) begin
            sram[i] = sram_init(i[15:0]);
        end
    end

    // Each bank written alone, the other keeps its byte
    always @(posedge core_clk) begin
        if (sram_wen[1]) begin
            sram[sram_addr][15:8] <= sram_wdata[15:8];
        end
        if (sram_wen[0]) begin
            sram[sram_addr][7:0] <= sram_wdata[7:0];
        end
    end

    // Unselected ports show inverted data so a stale read cannot pass
    assign code_rdata = code_rd ? code_val(code_addr) : ~code_val(code_addr);
    assign rom_rdata  = rom_rd ? rom_val({3'h0, rom_addr}) : ~rom_val({3'h0, rom_addr});
    assign sram_rdata = sram_rd ? sram[sram_addr] : ~sram[sram_addr];
endmodule : umm_mem_model
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the unified memory mapper
`default_nettype none
module tb
    import umm_pkg::*, umm_model_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                core_clk   = 1'h0;
    logic                reset      = 1'h1;
    logic [REG_AW-1:0]   reg_addr   = '0;
    logic [WORD_W-1:0]   reg_wdata  = '0;
    logic                reg_wr     = 1'h0;
    logic                reg_rd     = 1'h0;
    logic                fetch_req  = 1'h0;
    logic [ADDR_W-1:0]   fetch_addr = '0;
    umm_dreq_type        data_req   = '0;
    logic [WORD_W-1:0]   reg_rdata, fetch_word, data_rdata, code_rdata, rom_rdata;
    logic                fetch_valid, fetch_fault, data_ack, data_fault;
    logic [ADDR_W-1:0]   code_addr;
    logic                code_rd, rom_rd, sram_rd;
    logic [ROM_AW-1:0]   rom_addr;
    logic [SRAM_AW-1:0]  sram_addr;
    logic [1:0]          sram_wen;
    logic [WORD_W-1:0]   sram_wdata, sram_rdata, r1, a;
    logic [16:0]         fq[$], dq[$], rq[$];
    logic                rd_d = 1'h0;
    int                  n_fail = 0;
    int                  n_tests = 0;

    umm_mapper #(.WIDE_CORE(1'h1)) DUT (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .fetch_req, .fetch_addr, .fetch_valid, .fetch_word, .fetch_fault,
        .data_req, .data_ack, .data_rdata, .data_fault, .code_addr, .code_rd, .code_rdata,
        .rom_addr, .rom_rd, .rom_rdata, .sram_addr, .sram_rd, .sram_wen, .sram_wdata,
        .sram_rdata);
    umm_mem_model mem (.core_clk, .code_addr, .code_rd, .code_rdata, .rom_addr, .rom_rd,
        .rom_rdata, .sram_addr, .sram_rd, .sram_wen, .sram_wdata, .sram_rdata);

    always #50 core_clk = ~core_clk;

    task automatic cmp(input logic [16:0] got, input logic [16:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic cmp_fetch;
        cmp({fetch_fault, fetch_word}, fq.size() != 0 ? fq.pop_front() : 'x, "fetch");
    endtask : cmp_fetch

    task automatic cmp_data;
        cmp({data_fault, data_rdata}, dq.size() != 0 ? dq.pop_front() : 'x, "data");
    endtask : cmp_data

    task automatic cmp_reg;
        cmp({1'h0, reg_rdata}, rq.size() != 0 ? rq.pop_front() : 'x, "register");
    endtask : cmp_reg

    // Results carry no tag, so oldest note is matched first; a stray result meets x
    always @(posedge core_clk) begin
        if (fetch_valid === 1'h1) begin
            cmp_fetch();
        end
        if (data_ack === 1'h1) begin
            cmp_data();
        end
        if (rd_d) begin
            cmp_reg();
        end
        rd_d = reg_rd;
    end

    task automatic cyc(input logic fr, input logic [15:0] fa, input logic r, input logic w,
                       input logic [15:0] p, input logic [15:0] wd);
        fetch_req <= fr;
        fetch_addr <= fa;
        data_req <= '{rd: r, wr: w, ptr: p, wdata: wd};
        @(posedge core_clk);
        fetch_req <= 1'h0;
        data_req.rd <= 1'h0;
        data_req.wr <= 1'h0;
        @(posedge core_clk);
    endtask : cyc

    task automatic fx(input logic [15:0] fa, input logic [16:0] e);
        fq.push_back(e);
        cyc(1'h1, fa, 1'h0, 1'h0, '0, '0);
    endtask : fx

    task automatic dx(input logic r, input logic w, input logic [15:0] p,
                      input logic [15:0] wd, input logic [16:0] e);
        dq.push_back(e);
        cyc(1'h0, '0, r, w, p, wd);
    endtask : dx

    task automatic rw(input logic [3:0] ad, input logic [15:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        @(posedge core_clk);
    endtask : rw

    task automatic rr(input logic [3:0] ad, input logic [15:0] e);
        rq.push_back({1'h0, e});
        reg_addr <= ad;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        @(posedge core_clk);
    endtask : rr

    task automatic complete_run;
        if (fq.size() + dq.size() + rq.size() != 0) begin
            n_fail++;
        end
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (3000) @(posedge core_clk);
        n_fail++;
        complete_run();
    end

    initial begin
        void'($urandom(19));
        repeat (16) @(posedge core_clk);
        reset <= 1'h0;
        @(posedge core_clk);
        rr(4'h0, 16'h0004);
        rr(4'h1, 16'h0000);
        rr(4'h7, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            a = 16'($urandom_range(32'h7fff));
            fx(a, {1'h0, code_val(a)});
        end
        r1 = 16'($urandom);
        dx(1'h0, 1'h1, 16'h0001, r1, '0);
        dx(1'h1, 1'h0, 16'h0001, '0, {1'h0, r1});
        dx(1'h1, 1'h0, 16'h8005, '0, {1'h0, rom_val(16'h0005)});
        dx(1'h0, 1'h1, 16'h8005, r1, 17'h10000);
        // Fetch and data hit the SRAM in one cycle: fetch wins
        fq.push_back({1'h0, sram_init(16'h0003)});
        dq.push_back(17'h10000);
        cyc(1'h1, 16'ha003, 1'h1, 1'h0, 16'h0003, '0);
        fx(16'h0000, {1'h0, code_val(16'h0000)});
        rw(4'h0, 16'h0000);
        dx(1'h0, 1'h1, 16'h0003, 16'h00ab, '0);
        dx(1'h1, 1'h0, 16'h0002, '0, {9'h0, r1[7:0]});
        dx(1'h1, 1'h0, 16'h0003, '0, {9'h0, 8'hab});
        // Code word at even byte address 0002h, patched by a byte write to 0003h, runs as a whole word
        fx(16'ha001, {1'h0, 8'hab, r1[7:0]});
        fx(16'ha002, {1'h0, sram_init(16'h0002)});
        for (int c = 0; c < 4; c++) begin
            rw(4'h0, 16'(c));
            a = code_val({c[1:0], 14'h0010});
            dx(1'h1, 1'h0, 16'h0021, '0, {9'h0, a[15:8]});
        end
        rw(4'h0, 16'h0012);
        a = code_val({2'h2, 14'h0010});
        dx(1'h1, 1'h0, 16'h8020, '0, {9'h0, a[7:0]});
        a = rom_val(16'h0002);
        dx(1'h1, 1'h0, 16'h0005, '0, {9'h0, a[15:8]});
        fx(16'h8003, {1'h0, rom_val(16'h0003)});
        fx(16'h0100, {1'h0, code_val(16'h0100)});
        fx(16'ha004, {1'h0, sram_init(16'h0004)});
        for (int c = 0; c < 4; c++) begin
            rw(4'h0, 16'h0004 | 16'(c));
            dx(1'h1, 1'h0, 16'h0010, '0, {1'h0, code_val({c[1], 15'h0010})});
        end
        dx(1'h1, 1'h0, 16'h8007, '0, {1'h0, rom_val(16'h0007)});
        fx(16'he000, 17'h10000);
        rw(4'h0, 16'h0008);
        a = 16'h8000 | 16'($urandom_range(32'h7fff));
        fx(a, {1'h0, code_val(a)});
        fx(16'ha000, {1'h0, code_val(16'ha000)});
        fx(16'h8000, {1'h0, code_val(16'h8000)});
        rr(4'h1, 16'h001c);
        rw(4'h1, 16'h001c);
        rr(4'h1, 16'h0000);
        repeat (4) @(posedge core_clk);
        complete_run();
    end
endmodule : tb
`default_nettype wire
